//--- arj_top.sv
// Module: 10-bit conversion result justifier with APB register access
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module arj_top
   import arj_pkg::*;
#(
   parameter int CONV_CYC = ARJ_CONV_CYC
) (
   // Clock and reset
   input  wire logic                 MCLK,
   input  wire logic                 RST,
   // APB slave
   input  wire logic                 PSEL,
   input  wire logic                 PENABLE,
   input  wire logic                 PWRITE,
   input  wire logic [11:0]          PADDR,
   input  wire logic [31:0]          PWDATA,
   output var  logic [31:0]          PRDATA,
   output var  logic                 PREADY,
   output var  logic                 PSLVERR,
   // Converter core
   input  wire logic [ARJ_RES_W-1:0] CONV_DATA,
   output var  logic                 CONV_BUSY
);

   // ****************************************
   // State
   // ****************************************
   arj_state_e       state, next_state;
   logic [15:0]      count, next_count;
   logic             justify, next_justify;
   logic [7:0]       res_hi, next_res_hi;
   logic [7:0]       res_lo, next_res_lo;
   logic [31:0]      next_prdata;
   logic             next_pready, next_pslverr, next_busy;
   logic             wr, rd, done;

   function automatic logic [15:0] fmt(input logic j, input logic [ARJ_RES_W-1:0] v);
      if (j)
         fmt = {6'h00, v[9:8], v[7:0]};
      else
         fmt = {v[9:2], v[1:0], 6'h00};
   endfunction

   // One wait state: an access is taken only while PREADY is still low
   assign wr   = PSEL && PENABLE && PWRITE && !PREADY;
   assign rd   = PSEL && PENABLE && !PWRITE && !PREADY;
   assign done = (state == ARJ_CONV) && (count == 16'(CONV_CYC - 1));

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_state   = state;
      next_count   = count;
      next_justify = justify;
      next_res_hi  = res_hi;
      next_res_lo  = res_lo;
      next_prdata  = PRDATA;
      next_pready  = 1'b0;
      next_pslverr = 1'b0;
      unique case (state)
         ARJ_IDLE: begin
            if (wr && PADDR == ARJ_OFF_CTRL && PWDATA[ARJ_BIT_GO]) begin
               next_state = ARJ_CONV;
               next_count = 16'h0000;
            end
         end
         ARJ_CONV: begin
            next_count = count + 16'h0001;
            if (done) begin
               next_state = ARJ_IDLE;
               {next_res_hi, next_res_lo} = fmt(justify, CONV_DATA);
            end
         end
      endcase
      // Register access, decoded in the cycle before PREADY rises
      if (PSEL && PENABLE && !PREADY) begin
         next_pready = 1'b1;
         next_prdata = 32'h0000_0000;
         unique case (PADDR)
            ARJ_OFF_CTRL: begin
               next_prdata[ARJ_BIT_JUSTIFY] = justify;
               next_prdata[ARJ_BIT_GO]      = (state == ARJ_CONV);
               if (wr)
                  next_justify = PWDATA[ARJ_BIT_JUSTIFY];
            end
            ARJ_OFF_RES_HI: begin
               next_prdata[7:0] = res_hi;
               // Hardware load wins over a software write in the same cycle
               if (wr && !done)
                  next_res_hi = PWDATA[7:0];
            end
            ARJ_OFF_RES_LO: begin
               next_prdata[7:0] = res_lo;
               if (wr && !done)
                  next_res_lo = PWDATA[7:0];
            end
            ARJ_OFF_RAW: begin
               next_prdata[9:0] = CONV_DATA;
            end
            default: begin
               next_pslverr = 1'b1;
            end
         endcase
         if (!rd)
            next_prdata = 32'h0000_0000;
      end
      // Busy mirrors the state so that it rises with PREADY and falls with the load
      next_busy    = (next_state == ARJ_CONV);
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state     <= ARJ_IDLE;
         count     <= 16'h0000;
         justify   <= 1'b0;
         res_hi    <= ARJ_RES_RESET;
         res_lo    <= ARJ_RES_RESET;
         PRDATA    <= 32'h0000_0000;
         PREADY    <= 1'b0;
         PSLVERR   <= 1'b0;
         CONV_BUSY <= 1'b0;
      end else begin
         state     <= next_state;
         count     <= next_count;
         justify   <= next_justify;
         res_hi    <= next_res_hi;
         res_lo    <= next_res_lo;
         PRDATA    <= next_prdata;
         PREADY    <= next_pready;
         PSLVERR   <= next_pslverr;
         CONV_BUSY <= next_busy;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   sequence s_finish;
      state == ARJ_CONV ##1 state == ARJ_IDLE;
   endsequence

   sequence s_access;
      PSEL && PENABLE && !PREADY;
   endsequence

   // Start request taken while idle
   sequence s_go_idle;
      wr && PADDR == ARJ_OFF_CTRL && PWDATA[ARJ_BIT_GO] && state == ARJ_IDLE;
   endsequence

   // Result layout for each setting of justify
   a_left_high: assert property (@(posedge MCLK) disable iff (RST)
      (done && !justify) |=> res_hi == $past(CONV_DATA[9:2]))
      else $error("left high byte wrong");

   a_left_low: assert property (@(posedge MCLK) disable iff (RST)
      (done && !justify) |=> res_lo == {$past(CONV_DATA[1:0]), 6'h00})
      else $error("left low byte wrong");

   a_right_high: assert property (@(posedge MCLK) disable iff (RST)
      (done && justify) |=> res_hi == {6'h00, $past(CONV_DATA[9:8])})
      else $error("right high byte wrong");

   a_right_low: assert property (@(posedge MCLK) disable iff (RST)
      (done && justify) |=> res_lo == $past(CONV_DATA[7:0]))
      else $error("right low byte wrong");

   // Conversion control
   a_busy_clears: assert property (@(posedge MCLK) disable iff (RST)
      $rose(CONV_BUSY) |-> ##[1:300] !CONV_BUSY)
      else $error("busy never cleared");

   a_start_conv: assert property (@(posedge MCLK) disable iff (RST)
      s_go_idle |=> CONV_BUSY)
      else $error("busy not set by start");

   a_same_cycle: assert property (@(posedge MCLK) disable iff (RST)
      s_finish |-> !CONV_BUSY && ({res_hi, res_lo} == ($past(justify) ?
         {6'h00, $past(CONV_DATA)} : {$past(CONV_DATA), 6'h00})))
      else $error("busy not cleared with result");

   a_hold_results: assert property (@(posedge MCLK) disable iff (RST)
      (!done && !wr) |=> ($stable(res_hi) && $stable(res_lo)))
      else $error("result changed outside a load");

   a_value_split: assert property (@(posedge MCLK) disable iff (RST)
      done |=> ($past(justify) ? (res_hi[7:2] == 6'h00) : (res_lo[5:0] == 6'h00)))
      else $error("reserved result bits not zero");

   // Bus handshake
   a_apb_ready: assert property (@(posedge MCLK) disable iff (RST)
      s_access |=> PREADY)
      else $error("no ready after access");

   a_ready_pulse: assert property (@(posedge MCLK) disable iff (RST)
      PREADY |=> !PREADY)
      else $error("ready longer than one cycle");

   a_err_with_ready: assert property (@(posedge MCLK) disable iff (RST)
      PSLVERR |-> PREADY)
      else $error("error without ready");

   a_raw_read: assert property (@(posedge MCLK) disable iff (RST)
      (PSEL && PENABLE && !PREADY && !PWRITE && PADDR == ARJ_OFF_RAW)
      |=> PRDATA == {22'h000000, $past(CONV_DATA)})
      else $error("raw read wrong");

endmodule
`default_nettype wire

//--- arj_pkg.sv
// Package: register map, field layout and timing constants of the result justifier
package arj_pkg;
   // ****************************************
   // Register byte addresses
   // ****************************************
   localparam logic [11:0] ARJ_OFF_CTRL    = 12'h000;
   localparam logic [11:0] ARJ_OFF_RES_HI  = 12'h004;
   localparam logic [11:0] ARJ_OFF_RES_LO  = 12'h008;
   localparam logic [11:0] ARJ_OFF_RAW     = 12'h00c;
   // ****************************************
   // Control register fields and register reset values
   // ****************************************
   localparam int          ARJ_BIT_GO      = 0;
   localparam int          ARJ_BIT_JUSTIFY = 7;
   localparam logic [7:0]  ARJ_CTRL_RESET  = 8'h00;
   localparam logic [7:0]  ARJ_RES_RESET   = 8'h00;
   // ****************************************
   // Conversion timing, result width and controller states
   // ****************************************
   localparam int          ARJ_CLK_NS      = 40;
   localparam int          ARJ_CONV_NS     = 440;
   localparam int          ARJ_CONV_CYC    = (ARJ_CONV_NS + ARJ_CLK_NS - 1) / ARJ_CLK_NS;
   localparam int          ARJ_RES_W       = 10;
   typedef enum logic [0:0] {
      ARJ_IDLE = 1'b0,
      ARJ_CONV = 1'b1
   } arj_state_e;
endpackage

//--- arj_top_test.sv
// Testbench: APB access and result justification of arj_top
`timescale 1ns/1ps
`default_nettype none
module arj_top_test;
   import arj_pkg::*;
   localparam int CC = 2;
   logic MCLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic PREADY, PSLVERR, CONV_BUSY, err;
   logic [ARJ_RES_W-1:0] CONV_DATA = 10'h000;
   int failures = 0, check_count = 0, cycles = 0;
   arj_top #(.CONV_CYC(CC)) u_arj_top (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .CONV_DATA(CONV_DATA), .CONV_BUSY(CONV_BUSY));
   // ****************************************
   // Clock, timeout and shared tasks
   // ****************************************
   initial begin
      forever #20 MCLK = ~MCLK;
   end
   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("failures %0d checks %0d", failures, check_count);
      if (failures == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do @(posedge MCLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic convert(input logic j, input logic [9:0] v, output logic [31:0] hi,
                          output logic [31:0] lo);
      int n;
      CONV_DATA <= v;
      repeat (4) @(posedge MCLK);
      apb(1'b1, ARJ_OFF_CTRL, {24'h0, j, 6'h00, 1'b1});
      cmp({31'h0, CONV_BUSY}, 32'h1, "busy after start");
      n = 0;
      while (CONV_BUSY === 1'b1 && n < 20) begin
         @(posedge MCLK);
         n++;
      end
      cmp(n, CC - 1, "busy duration");
      apb(1'b0, ARJ_OFF_RES_HI, 32'h0);
      hi = rd;
      apb(1'b0, ARJ_OFF_RES_LO, 32'h0);
      lo = rd;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_reset();
      apb(1'b0, ARJ_OFF_CTRL, 32'h0);
      cmp(rd, {24'h0, ARJ_CTRL_RESET}, "ctrl reset");
      apb(1'b0, ARJ_OFF_RES_HI, 32'h0);
      cmp(rd, {24'h0, ARJ_RES_RESET}, "high reset");
      apb(1'b0, ARJ_OFF_RES_LO, 32'h0);
      cmp(rd, {24'h0, ARJ_RES_RESET}, "low reset");
   endtask
   task automatic test_left();
      logic [31:0] hi, lo;
      convert(1'b0, 10'h2d5, hi, lo);
      cmp(hi, 32'h000000b5, "left high");
      cmp(lo, 32'h00000040, "left low");
      convert(1'b0, 10'h3ff, hi, lo);
      cmp(hi, 32'h000000ff, "left high full");
      cmp(lo, 32'h000000c0, "left low full");
   endtask
   task automatic test_right();
      logic [31:0] hi, lo;
      convert(1'b1, 10'h2d5, hi, lo);
      cmp(hi, 32'h00000002, "right high");
      cmp(lo, 32'h000000d5, "right low");
      convert(1'b1, 10'h1a7, hi, lo);
      cmp(hi, 32'h00000001, "right high 2");
      cmp(lo, 32'h000000a7, "right low 2");
   endtask
   task automatic test_access();
      apb(1'b0, ARJ_OFF_CTRL, 32'h0);
      cmp(rd, 32'h00000080, "justify readback");
      cmp({31'h0, err}, 32'h0, "mapped no error");
      apb(1'b1, ARJ_OFF_RES_HI, 32'h000000a5);
      apb(1'b0, ARJ_OFF_RES_HI, 32'h0);
      cmp(rd, 32'h000000a5, "high write back");
      apb(1'b1, ARJ_OFF_RES_LO, 32'h0000005a);
      apb(1'b0, ARJ_OFF_RES_LO, 32'h0);
      cmp(rd, 32'h0000005a, "low write back");
      apb(1'b0, ARJ_OFF_RAW, 32'h0);
      cmp(rd, {22'h0, CONV_DATA}, "raw value");
      apb(1'b0, 12'h010, 32'h0);
      cmp({31'h0, err}, 32'h1, "unmapped error");
   endtask
   task automatic test_mid_reset();
      RST <= 1'b1;
      repeat (2) @(posedge MCLK);
      RST <= 1'b0;
      @(posedge MCLK);
      test_reset();
   endtask
   initial begin
      repeat (6) @(posedge MCLK);
      RST <= 1'b0;
      @(posedge MCLK);
      test_reset();
      test_left();
      test_right();
      test_access();
      test_mid_reset();
      print_verdict();
   end
endmodule
`default_nettype wire
